// ==== src/clk_ctrl_pkg.sv ====
// Constants and types shared by the clock control block.
// Operation
// (RULE_01) Source select 0110 enables the low-frequency watch crystal as system clock.
// (RULE_02) Low-frequency crystal start-up: 00 1K/4ms, 01 1K/64ms, 10 32K/64ms, 11 reserved.
// (RULE_03) Crystal upper select bits 100..111 pick the oscillator frequency range.
// (RULE_04) Crystal power-down start-up is 258, 1K or 16K cycles by select bit 0 and fuses.
// (RULE_05) Crystal reset delay is 14 cycles plus 4 ms, 64 ms or nothing by fuses.
// (RULE_06) With the brown-out detector off, wake-up stretches to about 60 microseconds.
// (RULE_07) Shipped fuses give internal 8 MHz, longest start-up and divide by eight.
// (RULE_08) One prescaler divides the source for CPU, I/O, ADC and flash domains alike.
// (RULE_09) Division changes are glitch free; no period shorter than old or new period.
// (RULE_10) New rate is active after one old plus one to two new periods, two edges.
// (RULE_11) Prescaler is a counter at the undivided rate; its count is not visible.
// (RULE_12) Clock output fuse drives the system clock on the pin, overriding the port.
// (RULE_13) No clock leaves on the output pin while reset is active.
// (RULE_14) The output pin carries the divided system clock for any source.
// (RULE_15) Select codes 0000..1000 divide by 1 to 256 in powers of two; rest reserved.
// (RULE_16) Set change enable with zeros, then write divider within four cycles.
// (RULE_17) Reset loads select 0011 with divide-by-eight fuse programmed, else 0000.
// (RULE_18) Reserved start-up and prescaler codes keep the previous or slowest setting.
package clk_ctrl_pkg;

  typedef enum logic [2:0] {
    SRC_EXTERNAL,
    SRC_RC8M,
    SRC_RC128K,
    SRC_LF_CRYSTAL,
    SRC_CRYSTAL,
    SRC_RESERVED
  } clk_src_t;

  typedef enum logic [1:0] {
    ST_RESET_DLY,
    ST_OSC_DLY,
    ST_RUN
  } startup_state_t;

  localparam logic [3:0] SEL_EXTERNAL   = 4'h0;
  localparam logic [3:0] SEL_RC8M       = 4'h2;
  localparam logic [3:0] SEL_RC128K     = 4'h4;
  localparam logic [3:0] SEL_LF_CRYSTAL = 4'h6;
  localparam logic [3:0] SEL_DEFAULT    = 4'h2;
  localparam logic [1:0] STARTUP_DEFAULT  = 2'h2;
  localparam logic [1:0] STARTUP_RESERVED = 2'h3;

  localparam logic [3:0] PS_DIV1    = 4'h0;
  localparam logic [3:0] PS_DIV8    = 4'h3;
  localparam logic [3:0] PS_MAX     = 4'h8;
  localparam int         PS_CNT_W   = 8;
  localparam logic [2:0] CE_TIMEOUT = 3'h4;

  // Oscillator cycle counts for the power-down part of start-up and the fixed 14-cycle part of the reset delay.
  localparam logic [15:0] CK_6   = 16'h0006;
  localparam logic [15:0] CK_258 = 16'h0102;
  localparam logic [15:0] CK_1K  = 16'h0400;
  localparam logic [15:0] CK_16K = 16'h4000;
  localparam logic [15:0] CK_32K = 16'h8000;
  localparam logic [15:0] CK_14  = 16'h000E;

  // Watchdog oscillator cycles for the real-time part of the reset delay.
  localparam logic [13:0] WDT_NONE = 14'h0000;
  localparam logic [13:0] WDT_4MS  = 14'h0200;
  localparam logic [13:0] WDT_64MS = 14'h2000;

  // Wake-up stretch with the brown-out detector off, in ns and in clk cycles.
  localparam int BROWNOUT_WAKE_NS  = 60000;
  localparam int CLK_NS            = 10;
  localparam int BROWNOUT_WAKE_CYC = (BROWNOUT_WAKE_NS + CLK_NS - 1) / CLK_NS;

endpackage

// ==== src/clk_prescaler.sv ====
// Glitch-free system clock prescaler driven by a clock enable.
module clk_prescaler
  import clk_ctrl_pkg::*;
#(
  parameter int CNT_W = PS_CNT_W
) (
  input  wire logic       clk,       // Master clock; the undivided source arrives as src_tick.
  input  wire logic       rstn,      // Synchronous reset, active low.
  input  wire logic       src_tick,  // One pulse per source cycle.
  input  wire logic [3:0] sel,       // Requested division select; taken at the next period boundary.
  output logic            sys_tick,  // One pulse per divided period.
  output logic            sys_clk_q  // Divided clock, high for the first half; toggles on each src_tick at division 1.
);

  logic [CNT_W-1:0] cnt_q;
  logic [3:0]       cur_q;
  logic             wrap;
  logic [CNT_W-1:0] lim;
  logic [CNT_W-1:0] half;

  // Terminal count and half point of the division currently in force.
  assign lim  = CNT_W'((9'h001 << cur_q) - 9'h001);
  assign half = CNT_W'(lim >> 1);
  assign wrap = src_tick && (cnt_q == lim);
  assign sys_tick = wrap;

  // Counter at the undivided rate; its count is never exported.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (wrap) begin
      cnt_q <= '0; // RULE_11
    end else if (src_tick) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // A new division is taken only at a period boundary, so no short period appears.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cur_q <= PS_DIV1;
    end else if (wrap || (src_tick && cur_q == PS_DIV1)) begin
      cur_q <= sel; // RULE_09 RULE_10
    end
  end

  // Clock level, high in the first half of each divided period; at divide by one it toggles on each source pulse.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sys_clk_q <= 1'b0;
    end else if (src_tick) begin
      sys_clk_q <= (cur_q == PS_DIV1) ? ~sys_clk_q : (wrap || cnt_q < half);
    end
  end

endmodule // clk_prescaler

// ==== src/clk_ctrl.sv ====
// Clock source decode, start-up delay, prescaler control and clock output.
module clk_ctrl
  import clk_ctrl_pkg::*;
#(
  parameter int WAKE_CYC = BROWNOUT_WAKE_CYC
) (
  input  wire logic       clk,             // Master clock, 100 MHz.
  input  wire logic       rstn,            // Synchronous reset, active low.
  input  wire logic       osc_tick,        // Selected oscillator cycle pulse.
  input  wire logic       wdt_tick,        // Watchdog oscillator cycle pulse.
  input  wire logic [3:0] clock_source_select_fuses, // Source select, 0 is programmed.
  input  wire logic [1:0] startup_time_fuses,        // Start-up time select.
  input  wire logic       divide_by_eight_fuse,      // Low when programmed.
  input  wire logic       clock_output_fuse,         // Low when programmed.
  input  wire logic       powerdown_wake,  // Pulse: leave power-down.
  input  wire logic       brownout_detector_off,     // Detector disabled by software.
  input  wire logic       reg_we,          // Pulse: prescaler control register write.
  input  wire logic [7:0] reg_wdata,       // Written control register value.
  input  wire logic       port_out,        // Normal port function for output pin.
  output logic [7:0]      reg_rdata_q,     // Control register read value.
  output logic [2:0]      src_q,           // Decoded clock source.
  output logic [2:0]      xtal_range_q,    // Crystal frequency range select.
  output logic            lf_xtal_en_q,    // Low-frequency crystal enabled.
  output logic            sys_clk_q,       // Divided system clock level.
  output logic            clk_cpu_en_q,    // CPU clock enable.
  output logic            clk_io_en_q,     // I/O clock enable.
  output logic            clk_adc_en_q,    // ADC clock enable.
  output logic            clk_flash_en_q,  // Flash clock enable.
  output logic            running_q,       // Start-up finished.
  output logic            clk_pin_q        // Clock output pin level.
);

  logic            osc_s1_q, osc_s2_q, osc_s3_q;
  logic            wdt_s1_q, wdt_s2_q, wdt_s3_q;
  logic            osc_ev, wdt_ev;
  clk_src_t        src_d;
  logic [15:0]     pd_ck;
  logic [13:0]     rst_wdt;
  logic            rst_ck14;
  logic [1:0]      start_sel_q;
  startup_state_t  st_q;
  logic [15:0]     ck_cnt_q;
  logic [13:0]     wdt_cnt_q;
  logic [31:0]     wake_cnt_q;
  logic            wake_long_q;
  logic            rst_seen_q;
  logic [3:0]      ps_q;
  logic            ce_q;
  logic [2:0]      ce_cnt_q;
  logic            sys_tick;
  logic            sys_lvl;
  logic            run;
  logic            ck14_done;

  // Oscillator pulses come from other domains and pass two flops first.
  // The third flop only remembers the previous synchronised level for edge detection.
  // Each source level must stand for two clk cycles or an edge may be lost.
  // Only the second and third flops of each chain feed logic beyond the chain, through the edge detect.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {osc_s1_q, osc_s2_q, osc_s3_q} <= 3'h0;
      {wdt_s1_q, wdt_s2_q, wdt_s3_q} <= 3'h0;
    end else begin
      {osc_s1_q, osc_s2_q, osc_s3_q} <= {osc_tick, osc_s1_q, osc_s2_q};
      {wdt_s1_q, wdt_s2_q, wdt_s3_q} <= {wdt_tick, wdt_s1_q, wdt_s2_q};
    end
  end
  assign osc_ev = osc_s2_q && !osc_s3_q;
  assign wdt_ev = wdt_s2_q && !wdt_s3_q;

  // The fixed oscillator part of the reset delay is done, or is not used by this source.
  assign ck14_done = !rst_ck14 || (ck_cnt_q >= CK_14);

  // Source decode from the select fuses.
  // Any code with the top bit set selects the crystal or resonator oscillator.
  // Unlisted codes decode to a reserved source that still starts with safe delays.
  // The fuses are static levels, so the decode needs no synchronising flops.
  always_comb begin
    if (clock_source_select_fuses[3]) begin
      src_d = SRC_CRYSTAL;
    end else begin
      case (clock_source_select_fuses)
        SEL_EXTERNAL:   src_d = SRC_EXTERNAL;
        SEL_RC8M:       src_d = SRC_RC8M; // RULE_07
        SEL_RC128K:     src_d = SRC_RC128K;
        SEL_LF_CRYSTAL: src_d = SRC_LF_CRYSTAL; // RULE_01
        default:        src_d = SRC_RESERVED;
      endcase
    end
  end

  // Start-up figures per source and start-up fuse setting.
  // Power-down wake counts oscillator cycles; the reset delay counts watchdog cycles.
  // The watch crystal has no fixed oscillator part in its reset delay.
  // Reserved start-up codes never reach this decode; the sampled setting keeps the last legal one.
  always_comb begin
    pd_ck    = CK_6;
    rst_wdt  = WDT_64MS;
    rst_ck14 = 1'b1;
    case (src_d)
      SRC_LF_CRYSTAL: begin
        rst_ck14 = 1'b0;
        case (start_sel_q)
          2'b00:   begin pd_ck = CK_1K;  rst_wdt = WDT_4MS;  end // RULE_02
          2'b01:   begin pd_ck = CK_1K;  rst_wdt = WDT_64MS; end // RULE_02
          default: begin pd_ck = CK_32K; rst_wdt = WDT_64MS; end // RULE_02 RULE_18
        endcase
      end
      SRC_CRYSTAL: begin
        case ({clock_source_select_fuses[0], start_sel_q})
          3'b000, 3'b001:         pd_ck = CK_258; // RULE_04
          3'b010, 3'b011, 3'b100: pd_ck = CK_1K;  // RULE_04
          default:                pd_ck = CK_16K; // RULE_04
        endcase
        case ({clock_source_select_fuses[0], start_sel_q})
          3'b000, 3'b011, 3'b110: rst_wdt = WDT_4MS;  // RULE_05
          3'b010, 3'b101:         rst_wdt = WDT_NONE; // RULE_05
          default:                rst_wdt = WDT_64MS; // RULE_05
        endcase
      end
      default: begin
        case (start_sel_q)
          2'b00:   rst_wdt = WDT_NONE;
          2'b01:   rst_wdt = WDT_4MS;
          default: rst_wdt = WDT_64MS; // RULE_18
        endcase
      end
    endcase
  end

  // Static fuse decodes, registered for the output pins.
  // Registering keeps every top-level output straight from a flip-flop.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      src_q        <= 3'(SRC_RC8M);
      xtal_range_q <= 3'h0;
      lf_xtal_en_q <= 1'b0;
    end else begin
      src_q        <= 3'(src_d);
      xtal_range_q <= (src_d == SRC_CRYSTAL) ? clock_source_select_fuses[3:1] : 3'h0; // RULE_03
      lf_xtal_en_q <= (src_d == SRC_LF_CRYSTAL); // RULE_01
    end
  end

  // Start-up fuses are sampled after reset; a reserved code keeps the last one.
  // A change made while running is only seen at the next start-up.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      start_sel_q <= STARTUP_DEFAULT;
    end else if (st_q != ST_RUN && startup_time_fuses != STARTUP_RESERVED) begin
      start_sel_q <= startup_time_fuses; // RULE_18
    end
  end

  // Start-up sequencer: reset delay then run, or oscillator cycles then run after a power-down wake.
  // The first cycle after reset clears the counters, so the delay always starts whole.
  // A wake from power-down is only honoured while running.
  // The reset-delay counters saturate at their targets; the power-down count runs on until the state is left.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q       <= ST_RESET_DLY;
      ck_cnt_q   <= '0;
      wdt_cnt_q  <= '0;
      rst_seen_q <= 1'b0;
    end else begin
      case (st_q)
        ST_RESET_DLY: begin
          if (!rst_seen_q) begin
            rst_seen_q <= 1'b1;
            ck_cnt_q   <= '0;
            wdt_cnt_q  <= '0;
          end else begin
            // The 14 oscillator cycles come first; the real-time part is added after them.
            if (osc_ev && rst_ck14 && ck_cnt_q < CK_14) begin
              ck_cnt_q <= ck_cnt_q + 16'h0001;
            end
            if (wdt_ev && ck14_done && wdt_cnt_q < rst_wdt) begin
              wdt_cnt_q <= wdt_cnt_q + 14'h0001;
            end
            if (ck14_done && wdt_cnt_q >= rst_wdt) begin
              st_q     <= ST_RUN; // RULE_05
              ck_cnt_q <= '0;
            end
          end
        end
        ST_OSC_DLY: begin
          if (osc_ev) ck_cnt_q <= ck_cnt_q + 16'h0001;
          if (ck_cnt_q >= pd_ck && !wake_long_q) st_q <= ST_RUN; // RULE_04
        end
        ST_RUN: begin
          if (powerdown_wake) begin
            st_q     <= ST_OSC_DLY;
            ck_cnt_q <= '0;
          end
        end
        default: st_q <= ST_RESET_DLY;
      endcase
    end
  end

  // Wake stretch so the brown-out detector settles before code runs.
  // The stretch runs beside the oscillator count; whichever ends last releases the core.
  // The length is a parameter so that a simulation may shorten it.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wake_cnt_q  <= '0;
      wake_long_q <= 1'b0;
    end else if (st_q == ST_RUN && powerdown_wake && brownout_detector_off) begin
      wake_cnt_q  <= 32'(WAKE_CYC); // RULE_06
      wake_long_q <= 1'b1;
    end else if (wake_cnt_q > 32'h0000_0001) begin
      wake_cnt_q <= wake_cnt_q - 32'h0000_0001;
    end else begin
      wake_cnt_q  <= '0;
      wake_long_q <= 1'b0;
    end
  end

  // Change-enable bit with a four-cycle window that rewrites do not extend.
  // Only an exact enable pattern arms it, which guards against stray writes.
  // Any select write with the enable bit clear closes the window at once.
  // The timeout clears the bit even when no select write follows.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ce_q     <= 1'b0;
      ce_cnt_q <= '0;
    end else if (reg_we && reg_wdata == 8'h80 && !ce_q) begin
      ce_q     <= 1'b1; // RULE_16
      ce_cnt_q <= CE_TIMEOUT;
    end else if (ce_q && (reg_we && !reg_wdata[7] || ce_cnt_q == 3'h1)) begin
      ce_q     <= 1'b0; // RULE_16
      ce_cnt_q <= '0;
    end else if (ce_q) begin
      ce_cnt_q <= ce_cnt_q - 3'h1;
    end
  end

  // Division select: fuse value at reset, protected writes later.
  // Reserved codes are dropped, so the previous division stays in force.
  // The prescaler itself decides when the new value reaches the clock.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ps_q <= PS_DIV1;
    end else if (!rst_seen_q) begin
      ps_q <= divide_by_eight_fuse ? PS_DIV1 : PS_DIV8; // RULE_17 RULE_07
    end else if (ce_q && reg_we && !reg_wdata[7] && reg_wdata[3:0] <= PS_MAX) begin
      ps_q <= reg_wdata[3:0]; // RULE_16 RULE_15 RULE_18
    end
  end

  // Register read view: change enable, zeros, division select.
  // The unused bits always read as zero.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= {ce_q, 3'h0, ps_q};
    end
  end

  // Clocks reach the domains only once start-up is complete.
  assign run = (st_q == ST_RUN);

  // The prescaler counts synchronised oscillator cycles and never shows its count.
  // Its division only changes at a period boundary, which keeps the output glitch free.
  clk_prescaler #(
    .CNT_W (PS_CNT_W)
  ) u_prescaler (
    .clk       (clk),
    .rstn      (rstn),
    .src_tick  (osc_ev),
    .sel       (ps_q),
    .sys_tick  (sys_tick),
    .sys_clk_q (sys_lvl)
  );

  // Same divided enable to every domain, only once start-up is done.
  // One shared pulse keeps the CPU, I/O, ADC and flash domains in step.
  // The level copy follows the prescaler with one cycle of latency.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {clk_cpu_en_q, clk_io_en_q, clk_adc_en_q, clk_flash_en_q} <= 4'h0;
      sys_clk_q <= 1'b0;
      running_q <= 1'b0;
    end else begin
      {clk_cpu_en_q, clk_io_en_q, clk_adc_en_q, clk_flash_en_q} <= {4{sys_tick && run}}; // RULE_08
      sys_clk_q <= sys_lvl;
      running_q <= run;
    end
  end

  // Clock output pin: divided clock when the fuse is programmed, held low in reset.
  // The clock is also held back in the first cycle after reset, until the sequencer has started.
  // With the fuse unprogrammed the pin simply carries the normal port level.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      clk_pin_q <= 1'b0; // RULE_13
    end else if (!clock_output_fuse) begin
      clk_pin_q <= sys_lvl && rst_seen_q; // RULE_12 RULE_14
    end else begin
      clk_pin_q <= port_out;
    end
  end

endmodule // clk_ctrl

// ==== verif/clk_ctrl_props.sv ====
// Port checks for the clock control block.
module clk_ctrl_props
  import clk_ctrl_pkg::*;
#(
  parameter int WAKE_CYC = 20
) (
  input wire logic       clk,                       // Clock.
  input wire logic       rstn,                      // Reset.
  input wire logic [3:0] clock_source_select_fuses, // Source fuses.
  input wire logic       clock_output_fuse,         // Output fuse.
  input wire logic       port_out,                  // Port level.
  input wire logic [7:0] reg_rdata_q,               // Register view.
  input wire logic [2:0] xtal_range_q,              // Crystal range.
  input wire logic       lf_xtal_en_q,              // Watch crystal on.
  input wire logic       sys_clk_q,                 // Divided clock.
  input wire logic       clk_cpu_en_q,              // CPU enable.
  input wire logic       clk_io_en_q,               // I/O enable.
  input wire logic       clk_adc_en_q,              // ADC enable.
  input wire logic       clk_flash_en_q,            // Flash enable.
  input wire logic       running_q,                 // Start-up done.
  input wire logic       clk_pin_q                  // Pin level.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Reset must silence the pin, so this one stays armed during reset.
  a_pin_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !clk_pin_q)
    else $error("clock pin active during reset");
  a_lf_decode: assert property ($past(rstn) |-> lf_xtal_en_q == (clock_source_select_fuses == SEL_LF_CRYSTAL))
    else $error("watch crystal enable wrong");
  a_range_decode: assert property ($past(rstn) |->
    xtal_range_q == (clock_source_select_fuses[3] ? clock_source_select_fuses[3:1] : 3'h0))
    else $error("crystal range wrong");
  a_domains_equal: assert property (clk_cpu_en_q == clk_io_en_q && clk_adc_en_q == clk_flash_en_q
    && clk_cpu_en_q == clk_adc_en_q)
    else $error("clock domains differ");
  a_select_legal: assert property (reg_rdata_q[3:0] <= PS_MAX && reg_rdata_q[6:4] == 3'h0)
    else $error("illegal select value");
  a_ce_timeout: assert property ($rose(reg_rdata_q[7]) |-> ##[1:4] !reg_rdata_q[7])
    else $error("change enable held too long");
  a_select_needs_ce: assert property ($past(rstn, 4) && $changed(reg_rdata_q[3:0]) |-> $past(reg_rdata_q[7]))
    else $error("select changed without enable");
  a_no_short_gap: assert property (clk_cpu_en_q |=> !clk_cpu_en_q [*3])
    else $error("divided period too short");
  a_pin_port: assert property ((clock_output_fuse && $stable(port_out)) [*3] |-> clk_pin_q == port_out)
    else $error("pin ignores port level");
  a_pin_clock: assert property (!clock_output_fuse && $rose(sys_clk_q) |-> ##[0:2] clk_pin_q)
    else $error("pin misses system clock");

  // Main scenarios seen.
  c_running: cover property ($rose(running_q));
  c_ce_set: cover property ($rose(reg_rdata_q[7]));
  c_pin_clock: cover property (!clock_output_fuse && $rose(clk_pin_q));
endmodule // clk_ctrl_props

bind clk_ctrl clk_ctrl_props #(.WAKE_CYC(WAKE_CYC)) u_props (.clk, .rstn, .clock_source_select_fuses,
  .clock_output_fuse, .port_out, .reg_rdata_q, .xtal_range_q, .lf_xtal_en_q, .sys_clk_q, .clk_cpu_en_q,
  .clk_io_en_q, .clk_adc_en_q, .clk_flash_en_q, .running_q, .clk_pin_q);

// ==== verif/osc_model.sv ====
// Oscillator and watchdog oscillator sources seen by the clock block.
module osc_model (
  input  wire logic clk,      // Bench clock.
  input  wire logic run,      // Oscillators enabled.
  output logic      osc_tick, // Oscillator output.
  output logic      wdt_tick  // Watchdog oscillator output.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Starts from zero so the phase counter never stays unknown while run is held high.
  logic [1:0] n = 2'd0;
  // Both run at a quarter of clk, two cycles high and two low, so the synchroniser sees every edge.
  always_ff @(posedge clk) begin
    n <= run ? n + 2'd1 : 2'd0;
    osc_tick <= run & n[1];
    wdt_tick <= run & n[1];
  end
endmodule // osc_model

// ==== verif/clk_ctrl_tb.sv ====
// Self-checking bench for the clock control block.
module clk_ctrl_tb
  import clk_ctrl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rstn = 0, pdw = 0, bdo = 0, we = 0, po = 0, d8 = 0, co = 1;
  logic [3:0] sel = SEL_DEFAULT;
  logic [1:0] stf = STARTUP_DEFAULT;
  logic [7:0] wd = 8'h00, rd;
  logic [2:0] src, rng;
  logic       osc, wdt, lfen, sclk, cpu, io, adc, fl, run_q, pin;
  int         n_fail = 0, n_compared = 0, c, k;

  clk_ctrl #(.WAKE_CYC(1500)) dut (.clk, .rstn, .osc_tick(osc), .wdt_tick(wdt), .clock_source_select_fuses(sel),
    .startup_time_fuses(stf), .divide_by_eight_fuse(d8), .clock_output_fuse(co), .powerdown_wake(pdw),
    .brownout_detector_off(bdo), .reg_we(we), .reg_wdata(wd), .port_out(po), .reg_rdata_q(rd), .src_q(src),
    .xtal_range_q(rng), .lf_xtal_en_q(lfen), .sys_clk_q(sclk), .clk_cpu_en_q(cpu), .clk_io_en_q(io),
    .clk_adc_en_q(adc), .clk_flash_en_q(fl), .running_q(run_q), .clk_pin_q(pin));
  osc_model osc_m (.clk, .run(1'b1), .osc_tick(osc), .wdt_tick(wdt));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic win(input int v, input int lo, input int hi);
    chk({15'h0, v >= lo && v <= hi}, 16'h0001);
  endtask

  // One-cycle write pulse; back-to-back calls land two cycles apart.
  task automatic wr(input logic [7:0] d);
    @(negedge clk);
    we = 1;
    wd = d;
    @(negedge clk);
    we = 0;
  endtask

  // Reset with the given fuses, then count cycles until start-up ends.
  task automatic boot(input logic [3:0] s, input logic [1:0] t, input logic d);
    @(negedge clk);
    rstn = 0;
    sel = s;
    stf = t;
    d8 = d;
    repeat (20) @(negedge clk);
    chk({15'h0, pin}, 16'h0000);
    rstn = 1;
    c = 0;
    while (run_q !== 1'b1 && c < 40000) begin
      @(negedge clk);
      c++;
    end
  endtask

  // Spacing of the last of three enable pulses, in clk cycles.
  task automatic per(input int exp);
    for (k = 0; k < 3; k++) begin
      c = 0;
      do begin
        @(negedge clk);
        c++;
      end while (cpu !== 1'b1 && c < 2000);
    end
    chk(c[15:0], exp[15:0]);
  endtask

  task automatic wake(input int lo, input int hi);
    @(negedge clk);
    pdw = 1;
    @(negedge clk);
    pdw = 0;
    @(negedge clk);
    chk({15'h0, run_q}, 16'h0000);
    c = 2;
    while (run_q !== 1'b1 && c < 5000) begin
      @(negedge clk);
      c++;
    end
    win(c, lo, hi);
  endtask

  // Hang guard, well beyond the expected run length.
  initial begin
    #1_000_000;
    n_fail++;
    final_report();
  end

  initial begin
    boot(SEL_DEFAULT, STARTUP_DEFAULT, 1'b0);
    win(c, 32824, 32900);
    chk({13'h0, src}, {13'h0, SRC_RC8M});
    chk({8'h0, rd}, 16'h0003);
    for (int i = 0; i <= 8; i++) begin
      wr(8'h80);
      wr(i[7:0]);
      per(4 << i);
      chk({8'h0, rd}, i[15:0]);
    end
    wr(8'h02);
    repeat (3) @(negedge clk);
    chk({8'h0, rd}, 16'h0008);
    wr(8'h80);
    wr(8'h09);
    repeat (6) @(negedge clk);
    chk({8'h0, rd}, 16'h0008);
    wr(8'h80);
    repeat (4) @(negedge clk);
    wr(8'h02);
    repeat (3) @(negedge clk);
    chk({8'h0, rd}, 16'h0008);
    wr(8'h81);
    wr(8'h02);
    repeat (3) @(negedge clk);
    chk({8'h0, rd}, 16'h0008);
    boot(SEL_LF_CRYSTAL, 2'h0, 1'b1);
    win(c, 2040, 2120);
    chk({15'h0, lfen}, 16'h0001);
    chk({13'h0, src}, {13'h0, SRC_LF_CRYSTAL});
    chk({8'h0, rd}, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      po = ~po;
      repeat (3) @(negedge clk);
      chk({15'h0, pin}, {15'h0, po});
    end
    co = 0;
    boot(4'hA, 2'h0, 1'b1);
    win(c, 2096, 2180);
    chk({13'h0, rng}, 16'h0005);
    chk({13'h0, src}, {13'h0, SRC_CRYSTAL});
    c = 0;
    k = 0;
    repeat (400) begin
      @(negedge clk);
      c += pin;
      k += sclk;
    end
    win(c, k - 2, k + 2);
    win(k, 150, 250);
    wake(1032, 1100);
    bdo = 1;
    wake(1500, 1520);
    final_report();
  end
endmodule // clk_ctrl_tb
